// ===== hdl/ica_pkg.sv
package ica_pkg;

  // Register addresses (8-bit register space)
  localparam logic [7:0] ADDR_SLOT_A_POL = 8'h17;
  localparam logic [7:0] ADDR_SLOT_B_POL = 8'h1d;
  localparam logic [7:0] ADDR_SIGN_MATH = 8'h58;
  localparam logic [7:0] ADDR_SLOT_A_CNT = 8'h31;
  localparam logic [7:0] ADDR_SLOT_B_CNT = 8'h36;

  localparam logic [15:0] RST_REG = 16'h0000;

  // Field positions
  localparam int POL_LSB = 0;
  localparam int POL_W = 4;
  localparam int A12_LSB = 1;
  localparam int B12_LSB = 5;
  localparam int A34_LSB = 8;
  localparam int B34_LSB = 10;
  localparam int SIGN_W = 2;
  localparam int CNT_LSB = 8;
  localparam int CNT_W = 8;

  localparam int ADC_W = 14;
  localparam int ACC_W = 27;

  typedef enum logic {ICA_SLOT_A, ICA_SLOT_B} ica_slot_t;

  // One digitized pulse result handed in by the converter
  typedef struct packed {
    logic valid;
    logic [13:0] data;
  } ica_pulse_t;

  // Register write strobe with address and data
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } ica_reg_wr_t;

endpackage : ica_pkg

// ===== hdl/ica_sign_sel.sv
`timescale 1ns/10ps
`default_nettype none

// Selects the polarity bit and the add/subtract sign for one pulse position
module ica_sign_sel
(
  input wire logic [1:0] i_pos,
  input wire logic [3:0] i_pattern,
  input wire logic [1:0] i_pair12,
  input wire logic [1:0] i_pair34,
  output logic o_reverse,
  output logic o_subtract
);

  always_comb
  begin
    o_reverse = i_pattern[i_pos];
    // pair encoding: high bit is first, low bit second
    case (i_pos)
      2'd0: o_subtract = i_pair12[1];
      2'd1: o_subtract = i_pair12[0];
      2'd2: o_subtract = i_pair34[1];
      2'd3: o_subtract = i_pair34[0];
      default: o_subtract = 1'b0;
    endcase
  end

endmodule // ica_sign_sel

`default_nettype wire

// ===== hdl/ica_top.sv
// Function
// - Integrator on/off phase switches in step with every light pulse.
// - Slot A pulse polarity comes from a 4-bit pattern, bit 0 first pulse.
// - Slot B has its own 4-bit polarity pattern, bit n for pulse n+1.
// - Pattern bit 0 gives normal order; 1 reverses the integration order.
// - The same pattern repeats for every later group of four pulses.
// - Each pulse result is added or subtracted into the sample per controls.
// - Slot B bits 11:10 sign pulses three and four, 00 add both.
// - Slot A bits 9:8 sign pulses three and four, same encoding.
// - Pulses one and two signed by bits 2:1 (A) and 6:5 (B).
// - Sign controls apply at matching positions of every four-pulse group.
// - Pair12 encoding: 00 add, 01 add/sub, 10 sub/add, 11 sub both.
// - Pulses per sample come from 8-bit count fields at bits 15:8.
`timescale 1ns/10ps
`default_nettype none

module ica_top
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire ica_pkg::ica_reg_wr_t i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_raddr,
  input wire logic i_sample_start,
  input wire ica_pkg::ica_slot_t i_slot,
  input wire logic i_pulse_start,
  input wire ica_pkg::ica_pulse_t i_pulse,
  output logic [15:0] o_reg_rdata,
  output logic o_integ_reverse,
  output logic o_integ_phase,
  output logic o_busy,
  output logic o_sample_valid,
  output logic [26:0] o_sample,
  output ica_pkg::ica_slot_t o_sample_slot
);

  logic [15:0] slot_a_integration_polarity;
  logic [15:0] slot_b_integration_polarity;
  logic [15:0] pulse_sign_math_control;
  logic [15:0] slot_a_pulse_count_reg;
  logic [15:0] slot_b_pulse_count_reg;

  ica_pkg::ica_slot_t slot;
  logic [7:0] pulses_left;
  logic [1:0] pos;
  logic [26:0] acc;

  logic [3:0] slot_a_polarity_pattern;
  logic [3:0] slot_b_polarity_pattern;
  logic [1:0] slot_a_pair12_sign;
  logic [1:0] slot_b_pair12_sign;
  logic [1:0] slot_a_pair34_sign;
  logic [1:0] slot_b_pair34_sign;
  logic [3:0] cur_pattern;
  logic [1:0] cur_pair12;
  logic [1:0] cur_pair34;
  logic cur_reverse;
  logic cur_subtract;
  logic [26:0] pulse_ext;
  logic [26:0] next_acc;
  logic [7:0] start_count;
  logic last_pulse;

  assign slot_a_polarity_pattern =
    slot_a_integration_polarity[ica_pkg::POL_LSB +: ica_pkg::POL_W];
  assign slot_b_polarity_pattern =
    slot_b_integration_polarity[ica_pkg::POL_LSB +: ica_pkg::POL_W];
  assign slot_a_pair12_sign =
    pulse_sign_math_control[ica_pkg::A12_LSB +: ica_pkg::SIGN_W];
  assign slot_b_pair12_sign =
    pulse_sign_math_control[ica_pkg::B12_LSB +: ica_pkg::SIGN_W];
  assign slot_a_pair34_sign =
    pulse_sign_math_control[ica_pkg::A34_LSB +: ica_pkg::SIGN_W];
  assign slot_b_pair34_sign =
    pulse_sign_math_control[ica_pkg::B34_LSB +: ica_pkg::SIGN_W];

  // Register writes
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      slot_a_integration_polarity <= ica_pkg::RST_REG;
      slot_b_integration_polarity <= ica_pkg::RST_REG;
      pulse_sign_math_control <= ica_pkg::RST_REG;
      slot_a_pulse_count_reg <= ica_pkg::RST_REG;
      slot_b_pulse_count_reg <= ica_pkg::RST_REG;
    end
    else if (i_reg_wr.wr)
    begin
      case (i_reg_wr.addr)
        ica_pkg::ADDR_SLOT_A_POL:
          slot_a_integration_polarity <= i_reg_wr.wdata;
        ica_pkg::ADDR_SLOT_B_POL:
          slot_b_integration_polarity <= i_reg_wr.wdata;
        ica_pkg::ADDR_SIGN_MATH: pulse_sign_math_control <= i_reg_wr.wdata;
        ica_pkg::ADDR_SLOT_A_CNT: slot_a_pulse_count_reg <= i_reg_wr.wdata;
        ica_pkg::ADDR_SLOT_B_CNT: slot_b_pulse_count_reg <= i_reg_wr.wdata;
        default:
        begin
        end
      endcase
    end
  end

  // Register reads, one cycle latency; unmapped reads as zero
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_reg_rdata <= ica_pkg::RST_REG;
    else if (i_reg_rd)
    begin
      case (i_reg_raddr)
        ica_pkg::ADDR_SLOT_A_POL: o_reg_rdata <= slot_a_integration_polarity;
        ica_pkg::ADDR_SLOT_B_POL: o_reg_rdata <= slot_b_integration_polarity;
        ica_pkg::ADDR_SIGN_MATH: o_reg_rdata <= pulse_sign_math_control;
        ica_pkg::ADDR_SLOT_A_CNT: o_reg_rdata <= slot_a_pulse_count_reg;
        ica_pkg::ADDR_SLOT_B_CNT: o_reg_rdata <= slot_b_pulse_count_reg;
        default: o_reg_rdata <= ica_pkg::RST_REG;
      endcase
    end
  end

  always_comb
  begin
    if (slot == ica_pkg::ICA_SLOT_B)
    begin
      cur_pattern = slot_b_polarity_pattern;
      cur_pair12 = slot_b_pair12_sign;
      cur_pair34 = slot_b_pair34_sign;
    end
    else
    begin
      cur_pattern = slot_a_polarity_pattern;
      cur_pair12 = slot_a_pair12_sign;
      cur_pair34 = slot_a_pair34_sign;
    end
  end

  ica_sign_sel u_sign_sel
  (
    .i_pos(pos),
    .i_pattern(cur_pattern),
    .i_pair12(cur_pair12),
    .i_pair34(cur_pair34),
    .o_reverse(cur_reverse),
    .o_subtract(cur_subtract)
  );

  assign start_count = (i_slot == ica_pkg::ICA_SLOT_B) ?
    slot_b_pulse_count_reg[ica_pkg::CNT_LSB +: ica_pkg::CNT_W] :
    slot_a_pulse_count_reg[ica_pkg::CNT_LSB +: ica_pkg::CNT_W];

  assign pulse_ext = {{(ica_pkg::ACC_W - ica_pkg::ADC_W){1'b0}},
    i_pulse.data};
  assign last_pulse = (pulses_left == 8'h01);

  // signed accumulation; all-zero controls only add
  always_comb
  begin
    if (cur_subtract)
      next_acc = acc - pulse_ext;
    else
      next_acc = acc + pulse_ext;
  end

  // Sample sequencing
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      slot <= ica_pkg::ICA_SLOT_A;
      pulses_left <= 8'h00;
      pos <= 2'h0;
      acc <= 27'h0000000;
      o_busy <= 1'b0;
    end
    else if (i_sample_start && !o_busy)
    begin
      slot <= i_slot;
      pulses_left <= start_count;
      pos <= 2'h0;
      acc <= 27'h0000000;
      // A zero pulse count starts nothing
      o_busy <= (start_count != 8'h00);
    end
    else if (o_busy && i_pulse.valid)
    begin
      acc <= next_acc;
      pos <= pos + 2'h1;
      pulses_left <= pulses_left - 8'h01;
      if (last_pulse)
        o_busy <= 1'b0;
    end
  end

  // Finished sample output, pulse for one cycle
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_sample_valid <= 1'b0;
      o_sample <= 27'h0000000;
      o_sample_slot <= ica_pkg::ICA_SLOT_A;
    end
    else
    begin
      o_sample_valid <= o_busy && i_pulse.valid && last_pulse;
      if (o_busy && i_pulse.valid && last_pulse)
      begin
        o_sample <= next_acc;
        o_sample_slot <= slot;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_integ_reverse <= 1'b0;
      o_integ_phase <= 1'b0;
    end
    else if (o_busy && i_pulse_start)
    begin
      o_integ_reverse <= cur_reverse;
      o_integ_phase <= 1'b1;
    end
    else if (o_busy && i_pulse.valid)
      o_integ_phase <= 1'b0;
    else if (!o_busy)
      o_integ_phase <= 1'b0;
  end

endmodule // ica_top

`default_nettype wire

// ===== test/ica_chk.sv
`timescale 1ns/10ps
`default_nettype none
module ica_chk
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire ica_pkg::ica_reg_wr_t i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_raddr,
  input wire logic i_pulse_start,
  input wire ica_pkg::ica_pulse_t i_pulse,
  input wire logic [15:0] o_reg_rdata,
  input wire logic o_integ_reverse,
  input wire logic o_integ_phase,
  input wire logic o_busy,
  input wire logic o_sample_valid
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_wr;
    i_reg_wr.wr && i_reg_wr.addr == ica_pkg::ADDR_SLOT_A_POL;
  endsequence
  sequence s_rd;
    i_reg_rd && i_reg_raddr == ica_pkg::ADDR_SLOT_A_POL;
  endsequence
  property p_rdback;
    s_wr ##2 s_rd |=> o_reg_rdata == $past(i_reg_wr.wdata, 3);
  endproperty
  a_rdback: assert property (p_rdback) else $error("readback");
  property p_ph_on;
    o_busy && i_pulse_start |=> o_integ_phase;
  endproperty
  a_ph_on: assert property (p_ph_on) else $error("phase on");
  property p_ph_off;
    o_busy && i_pulse.valid && !i_pulse_start |=> !o_integ_phase;
  endproperty
  a_ph_off: assert property (p_ph_off) else $error("phase off");
  property p_ph_hold;
    o_integ_phase && !i_pulse.valid |=> o_integ_phase;
  endproperty
  a_ph_hold: assert property (p_ph_hold) else $error("phase hold");
  property p_rev;
    $changed(o_integ_reverse) |-> $past(o_busy && i_pulse_start);
  endproperty
  a_rev: assert property (p_rev) else $error("reverse change");
  property p_end;
    o_sample_valid |-> !o_busy && $past(o_busy);
  endproperty
  a_end: assert property (p_end) else $error("sample end");
  property p_one;
    o_sample_valid |=> !o_sample_valid;
  endproperty
  a_one: assert property (p_one) else $error("valid width");
  property p_busy;
    o_busy && !i_pulse.valid |=> o_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy drop");
endmodule // ica_chk
bind ica_top ica_chk i_ica_chk (.i_clk, .i_sys_rst, .i_reg_wr, .i_reg_rd,
  .i_reg_raddr, .i_pulse_start, .i_pulse, .o_reg_rdata, .o_integ_reverse,
  .o_integ_phase, .o_busy, .o_sample_valid);
`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  logic i_clk, i_sys_rst, i_reg_rd, i_sample_start, i_pulse_start;
  logic [7:0] i_reg_raddr;
  ica_pkg::ica_reg_wr_t i_reg_wr;
  ica_pkg::ica_slot_t i_slot, o_sample_slot;
  ica_pkg::ica_pulse_t i_pulse;
  logic [15:0] o_reg_rdata;
  logic o_integ_reverse, o_integ_phase, o_busy, o_sample_valid;
  logic [26:0] o_sample;
  int fails, n_compared;
  logic [7:0] adr [5] = '{ica_pkg::ADDR_SLOT_A_POL, ica_pkg::ADDR_SLOT_B_POL,
    ica_pkg::ADDR_SIGN_MATH, ica_pkg::ADDR_SLOT_A_CNT,
    ica_pkg::ADDR_SLOT_B_CNT};
  ica_top i_ica_top (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_raddr(i_reg_raddr),
    .i_sample_start(i_sample_start), .i_slot(i_slot),
    .i_pulse_start(i_pulse_start), .i_pulse(i_pulse),
    .o_reg_rdata(o_reg_rdata), .o_integ_reverse(o_integ_reverse),
    .o_integ_phase(o_integ_phase), .o_busy(o_busy),
    .o_sample_valid(o_sample_valid), .o_sample(o_sample),
    .o_sample_slot(o_sample_slot));
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_reg_wr <= '{1'b1, a, d};
    @(posedge i_clk);
    i_reg_wr.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_raddr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1 `CHK(o_reg_rdata, e)
  endtask
  task automatic run(input ica_pkg::ica_slot_t s, input logic [3:0] pat,
                     input logic [15:0] m, input int n);
    logic [3:0] sg;
    logic [26:0] ex;
    logic [13:0] d;
    sg = s ? {m[6:5], m[11:10]} : {m[2:1], m[9:8]};
    ex = '0;
    wr(s ? ica_pkg::ADDR_SLOT_B_POL : ica_pkg::ADDR_SLOT_A_POL, 16'(pat));
    wr(s ? ica_pkg::ADDR_SLOT_B_CNT : ica_pkg::ADDR_SLOT_A_CNT, 16'(n << 8));
    wr(ica_pkg::ADDR_SIGN_MATH, m);
    @(posedge i_clk);
    i_sample_start <= 1'b1;
    i_slot <= s;
    @(posedge i_clk);
    i_sample_start <= 1'b0;
    #1 `CHK(o_busy, 1'b1)
    for (int k = 0; k < n; k++)
    begin
      d = k[0] ? 14'h3fff : 14'(k * 300 + 7);
      // Position sign repeats every four pulses
      ex = sg[3 - k % 4] ? ex - 27'(d) : ex + 27'(d);
      @(posedge i_clk);
      i_pulse_start <= 1'b1;
      // A start while busy must be ignored, or the sum would restart
      i_sample_start <= (k == 1);
      @(posedge i_clk);
      i_pulse_start <= 1'b0;
      i_sample_start <= 1'b0;
      i_pulse <= '{1'b1, d};
      #1 `CHK(o_integ_reverse, pat[k % 4])
      `CHK(o_integ_phase, 1'b1)
      @(posedge i_clk);
      i_pulse <= '0;
    end
    #1 `CHK(o_sample_valid, 1'b1)
    `CHK(o_sample, ex)
    `CHK(o_sample_slot, s)
    `CHK(o_busy, 1'b0)
    $display("sample test done, slot %0d pulses %0d", s, n);
  endtask
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #(5000 * 50);
    fails++;
    $display("unexpected t=%0t watchdog expired", $time);
    end_sim();
  end
  initial
  begin
    i_sys_rst = 1'b1;
    i_reg_wr = '0;
    i_reg_rd = 1'b0;
    i_reg_raddr = 8'h00;
    i_sample_start = 1'b0;
    i_slot = ica_pkg::ICA_SLOT_A;
    i_pulse_start = 1'b0;
    i_pulse = '0;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    foreach (adr[i]) rd(adr[i], 16'h0000);
    foreach (adr[i])
    begin
      wr(adr[i], 16'h5a3c ^ 16'(i));
      rd(adr[i], 16'h5a3c ^ 16'(i));
    end
    wr(8'h20, 16'h0000);
    rd(8'h20, 16'h0000);
    $display("register test done");
    wr(ica_pkg::ADDR_SLOT_A_CNT, 16'h0000);
    @(posedge i_clk);
    i_sample_start <= 1'b1;
    @(posedge i_clk);
    i_sample_start <= 1'b0;
    #1 `CHK(o_busy, 1'b0)
    $display("zero count test done");
    run(ica_pkg::ICA_SLOT_A, 4'h0, 16'h0000, 4);
    run(ica_pkg::ICA_SLOT_A, 4'ha, 16'h0d42, 6);
    run(ica_pkg::ICA_SLOT_B, 4'h6, 16'h0d42, 16);
    for (int c = 0; c < 4; c++)
    begin
      run(ica_pkg::ICA_SLOT_A, 4'(c * 5),
          16'(c << 8 | (3 - c) << 1), 4);
      run(ica_pkg::ICA_SLOT_B, 4'(c * 3), 16'(c << 10 | c << 5), 4);
    end
    end_sim();
  end
endmodule // testbench
`default_nettype wire
